// file: dsa_pkg.sv
// Shared constants, register map and types of the source audio packet configuration block.
package dsa_pkg;

   // ==========================================================================
   // Register map
   // ==========================================================================
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 32;

   localparam logic [ADDR_W-1:0] OFS_AUD_CTRL   = 12'h300;
   localparam logic [ADDR_W-1:0] OFS_CHAN_CNT   = 12'h304;
   localparam logic [ADDR_W-1:0] OFS_INFO_DATA  = 12'h308;
   localparam logic [ADDR_W-1:0] OFS_M_VALUE    = 12'h328;
   localparam logic [ADDR_W-1:0] OFS_N_VALUE    = 12'h32C;
   localparam logic [ADDR_W-1:0] OFS_EXT_DATA   = 12'h330;
   localparam logic [ADDR_W-1:0] OFS_EXT_LAST   = 12'h350;

   // ==========================================================================
   // Field layout
   // ==========================================================================
   localparam int unsigned NUM_STREAMS  = 4;
   localparam int unsigned CTRL_EN_LSB  = 0;
   localparam int unsigned CTRL_MUTE_LSB = 16;
   localparam int unsigned CHAN_W       = 3;
   localparam int unsigned MN_W         = 24;

   // ==========================================================================
   // Reset values
   // ==========================================================================
   localparam logic [NUM_STREAMS-1:0] RST_AUD_EN   = 4'h0;
   localparam logic [NUM_STREAMS-1:0] RST_AUD_MUTE = 4'h0;
   localparam logic [CHAN_W-1:0]      RST_CHAN_CNT = 3'h0;
   localparam logic [MN_W-1:0]        RST_MN       = 24'h00_0000;

   // ==========================================================================
   // Packet storage
   // ==========================================================================
   localparam int unsigned EXT_BYTES  = 32;
   localparam int unsigned HDR_WORDS  = 1;
   localparam int unsigned INFO_WORDS = 8;
   localparam int unsigned EXT_WORDS  = HDR_WORDS + EXT_BYTES / 4;
   localparam int unsigned MEM_AW     = 5;
   localparam int unsigned MEM_DEPTH  = 32;
   localparam logic [MEM_AW-1:0] INFO_BASE = 5'h00;
   localparam logic [MEM_AW-1:0] EXT_BASE  = 5'h08;
   localparam logic [2:0] INFO_LAST_IDX = 3'h7;
   localparam logic [3:0] EXT_LAST_IDX  = 4'h8;

   localparam logic KIND_INFO = 1'b0;
   localparam logic KIND_EXT  = 1'b1;

   // ==========================================================================
   // Bus answers and sender states
   // ==========================================================================
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [1:0]
   {
      SND_IDLE = 2'b00,
      SND_READ = 2'b01,
      SND_PUSH = 2'b10
   } dsa_snd_t;

endpackage

// file: dsa_pkt_mem.sv
// Small packet store with one write port and a registered read port.
`timescale 1ns/1ps

module dsa_pkt_mem
#(
   parameter int unsigned DATA_W = 32,
   parameter int unsigned ADDR_W = 5,
   parameter int unsigned DEPTH  = 32
)
(
   input  wire logic              i_core_clk,
   input  wire logic              i_rst,
   input  wire logic              i_wr_en,
   input  wire logic [ADDR_W-1:0] i_wr_addr,
   input  wire logic [DATA_W-1:0] i_wr_data,
   input  wire logic              i_rd_en,
   input  wire logic [ADDR_W-1:0] i_rd_addr,
   output logic      [DATA_W-1:0] o_rd_data
);

   // The array has no reset so that it maps onto distributed memory.
   logic [DATA_W-1:0] mem [DEPTH];
   logic [DATA_W-1:0] rd_data_q;

   always_ff @(posedge i_core_clk)
   begin
      if (i_wr_en)
      begin
         mem[i_wr_addr] <= i_wr_data;
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         rd_data_q <= '0;
      end
      else if (i_rd_en)
      begin
         rd_data_q <= mem[i_rd_addr];
      end
   end

   assign o_rd_data = rd_data_q;

endmodule // dsa_pkt_mem

// file: dsa_audio_cfg.sv
// Audio enable, mute, channel count, M/N values and key-hole packet windows with a packet sender.
`timescale 1ns/1ps

module dsa_audio_cfg
(
   input  wire logic                                i_core_clk,
   input  wire logic                                i_rst,
   // AXI4-Lite slave.
   input  wire logic [dsa_pkg::ADDR_W-1:0]          i_s_axi_awaddr,
   input  wire logic                                i_s_axi_awvalid,
   output logic                                     o_s_axi_awready,
   input  wire logic [dsa_pkg::DATA_W-1:0]          i_s_axi_wdata,
   input  wire logic [dsa_pkg::DATA_W/8-1:0]        i_s_axi_wstrb,
   input  wire logic                                i_s_axi_wvalid,
   output logic                                     o_s_axi_wready,
   output logic [1:0]                               o_s_axi_bresp,
   output logic                                     o_s_axi_bvalid,
   input  wire logic                                i_s_axi_bready,
   input  wire logic [dsa_pkg::ADDR_W-1:0]          i_s_axi_araddr,
   input  wire logic                                i_s_axi_arvalid,
   output logic                                     o_s_axi_arready,
   output logic [dsa_pkg::DATA_W-1:0]               o_s_axi_rdata,
   output logic [1:0]                               o_s_axi_rresp,
   output logic                                     o_s_axi_rvalid,
   input  wire logic                                i_s_axi_rready,
   // Transport mode and computed M/N values from the link side.
   input  wire logic                                i_mst_mode,
   input  wire logic                                i_mn_update,
   input  wire logic [dsa_pkg::MN_W-1:0]            i_audio_m,
   input  wire logic [dsa_pkg::MN_W-1:0]            i_audio_n,
   // Per-stream audio enable and mute, and shared channel count and M/N values, to the framer and sample collector.
   output logic [dsa_pkg::NUM_STREAMS-1:0]          o_stream_audio_en,
   output logic [dsa_pkg::NUM_STREAMS-1:0]          o_stream_audio_mute,
   output logic [dsa_pkg::CHAN_W-1:0]               o_audio_channel_count,
   output logic [dsa_pkg::MN_W-1:0]                 o_audio_m_value,
   output logic [dsa_pkg::MN_W-1:0]                 o_audio_n_value,
   // Packet words toward the main-link framer.
   output logic                                     o_pkt_valid,
   input  wire logic                                i_pkt_ready,
   output logic [dsa_pkg::DATA_W-1:0]               o_pkt_data,
   output logic                                     o_pkt_first,
   output logic                                     o_pkt_last,
   output logic                                     o_pkt_kind
);

   // ==========================================================================
   // State
   // ==========================================================================
   typedef struct packed
   {
      logic [dsa_pkg::NUM_STREAMS-1:0] aud_en;
      logic [dsa_pkg::NUM_STREAMS-1:0] aud_mute;
      logic [dsa_pkg::CHAN_W-1:0]      chan_cnt;
      logic [dsa_pkg::MN_W-1:0]        m_val;
      logic [dsa_pkg::MN_W-1:0]        n_val;
      logic [2:0]                      info_ptr;
      logic [3:0]                      ext_ptr;
      logic                            info_pend;
      logic                            ext_pend;
      logic                            bvalid;
      logic [1:0]                      bresp;
      logic                            rvalid;
      logic [1:0]                      rresp;
      logic [dsa_pkg::DATA_W-1:0]      rdata;
      dsa_pkg::dsa_snd_t               snd;
      logic                            snd_kind;
      logic [3:0]                      snd_idx;
      logic [1:0][dsa_pkg::DATA_W-1:0] fifo_data;
      logic [1:0]                      fifo_first;
      logic [1:0]                      fifo_last;
      logic [1:0]                      fifo_kind;
      logic                            fifo_wp;
      logic                            fifo_rp;
      logic [1:0]                      fifo_cnt;
   } dsa_state_t;

   dsa_state_t                 s_q;
   dsa_state_t                 s_d;
   logic                       wr_fire;
   logic                       rd_fire;
   logic                       mem_wr_en;
   logic [dsa_pkg::MEM_AW-1:0] mem_wr_addr;
   logic                       mem_rd_en;
   logic [dsa_pkg::MEM_AW-1:0] mem_rd_addr;
   logic [dsa_pkg::DATA_W-1:0] mem_rd_data;
   logic                       fifo_full;
   logic                       fifo_pop;
   logic                       audio_any;

   // Byte-lane merge for the read/write registers.
   function automatic logic [31:0] dsa_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++)
      begin
         if (strb[b])
         begin
            res[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return res;
   endfunction

   // ==========================================================================
   // Per-stream gating
   // ==========================================================================
   // Stream zero is the single-stream audio path; the others only exist in MST.
   for (genvar g = 0; g < dsa_pkg::NUM_STREAMS; g++)
   begin : g_stream
      if (g == 0)
      begin : g_first
         assign o_stream_audio_en[g]   = s_q.aud_en[g];
         assign o_stream_audio_mute[g] = s_q.aud_mute[g];
      end
      else
      begin : g_other
         assign o_stream_audio_en[g]   = s_q.aud_en[g] & i_mst_mode;
         assign o_stream_audio_mute[g] = s_q.aud_mute[g] & i_mst_mode;
      end
   end

   assign audio_any             = |o_stream_audio_en;
   assign o_audio_channel_count = s_q.chan_cnt;
   assign o_audio_m_value       = s_q.m_val;
   assign o_audio_n_value       = s_q.n_val;

   // ==========================================================================
   // Bus handshakes and buffer status
   // ==========================================================================
   assign wr_fire         = i_s_axi_awvalid & i_s_axi_wvalid & ~s_q.bvalid;
   assign rd_fire         = i_s_axi_arvalid & ~s_q.rvalid;
   assign o_s_axi_awready = wr_fire;
   assign o_s_axi_wready  = wr_fire;
   assign o_s_axi_arready = rd_fire;
   assign o_s_axi_bvalid  = s_q.bvalid;
   assign o_s_axi_bresp   = s_q.bresp;
   assign o_s_axi_rvalid  = s_q.rvalid;
   assign o_s_axi_rresp   = s_q.rresp;
   assign o_s_axi_rdata   = s_q.rdata;

   assign fifo_full   = (s_q.fifo_cnt == 2'd2);
   assign fifo_pop    = o_pkt_valid & i_pkt_ready;
   assign o_pkt_valid = (s_q.fifo_cnt != 2'd0);
   assign o_pkt_data  = s_q.fifo_data[s_q.fifo_rp];
   assign o_pkt_first = s_q.fifo_first[s_q.fifo_rp];
   assign o_pkt_last  = s_q.fifo_last[s_q.fifo_rp];
   assign o_pkt_kind  = s_q.fifo_kind[s_q.fifo_rp];

   // ==========================================================================
   // Next state
   // ==========================================================================
   always_comb
   begin
      logic        info_done;
      logic        ext_done;
      logic        push;
      logic [31:0] wr_word;
      s_d         = s_q;
      info_done   = 1'b0;
      ext_done    = 1'b0;
      push        = 1'b0;
      wr_word     = '0;
      mem_wr_en   = 1'b0;
      mem_wr_addr = dsa_pkg::INFO_BASE;
      mem_rd_en   = 1'b0;
      mem_rd_addr = dsa_pkg::INFO_BASE;

      // Register writes.
      if (wr_fire)
      begin
         s_d.bvalid = 1'b1;
         s_d.bresp  = dsa_pkg::RESP_OKAY;
         if (i_s_axi_awaddr == dsa_pkg::OFS_AUD_CTRL)
         begin
            wr_word    = dsa_merge({12'h000, s_q.aud_mute, 12'h000, s_q.aud_en}, i_s_axi_wdata, i_s_axi_wstrb);
            s_d.aud_en   = wr_word[dsa_pkg::CTRL_EN_LSB +: dsa_pkg::NUM_STREAMS];
            s_d.aud_mute = wr_word[dsa_pkg::CTRL_MUTE_LSB +: dsa_pkg::NUM_STREAMS];
         end
         else if (i_s_axi_awaddr == dsa_pkg::OFS_CHAN_CNT)
         begin
            wr_word      = dsa_merge({29'h0000_0000, s_q.chan_cnt}, i_s_axi_wdata, i_s_axi_wstrb);
            s_d.chan_cnt = wr_word[dsa_pkg::CHAN_W-1:0];
         end
         else if (i_s_axi_awaddr == dsa_pkg::OFS_M_VALUE)
         begin
            wr_word   = dsa_merge({8'h00, s_q.m_val}, i_s_axi_wdata, i_s_axi_wstrb);
            s_d.m_val = wr_word[dsa_pkg::MN_W-1:0];
         end
         else if (i_s_axi_awaddr == dsa_pkg::OFS_N_VALUE)
         begin
            wr_word   = dsa_merge({8'h00, s_q.n_val}, i_s_axi_wdata, i_s_axi_wstrb);
            s_d.n_val = wr_word[dsa_pkg::MN_W-1:0];
         end
         else if (i_s_axi_awaddr == dsa_pkg::OFS_INFO_DATA)
         begin
            // Whole words go in as written; order and count are software's duty.
            mem_wr_en   = 1'b1;
            mem_wr_addr = dsa_pkg::INFO_BASE + {2'b00, s_q.info_ptr};
            if (s_q.info_ptr == dsa_pkg::INFO_LAST_IDX)
            begin
               s_d.info_ptr = 3'h0;
               info_done    = 1'b1;
            end
            else
            begin
               s_d.info_ptr = s_q.info_ptr + 3'h1;
            end
         end
         else if ((i_s_axi_awaddr >= dsa_pkg::OFS_EXT_DATA) && (i_s_axi_awaddr <= dsa_pkg::OFS_EXT_LAST))
         begin
            // Any address of the extension space is the same key-hole.
            mem_wr_en   = 1'b1;
            mem_wr_addr = dsa_pkg::EXT_BASE + {1'b0, s_q.ext_ptr};
            if (s_q.ext_ptr == dsa_pkg::EXT_LAST_IDX)
            begin
               s_d.ext_ptr = 4'h0;
               ext_done    = 1'b1;
            end
            else
            begin
               s_d.ext_ptr = s_q.ext_ptr + 4'h1;
            end
         end
         else
         begin
            s_d.bresp = dsa_pkg::RESP_SLVERR;
         end
      end
      else if (s_q.bvalid && i_s_axi_bready)
      begin
         s_d.bvalid = 1'b0;
      end

      // A computed M/N pair from the link side overrides a software write.
      if (i_mn_update)
      begin
         s_d.m_val = i_audio_m;
         s_d.n_val = i_audio_n;
      end

      // Register reads; the key-hole windows read as zero.
      if (rd_fire)
      begin
         s_d.rvalid = 1'b1;
         s_d.rresp  = dsa_pkg::RESP_OKAY;
         s_d.rdata  = '0;
         if (i_s_axi_araddr == dsa_pkg::OFS_AUD_CTRL)
         begin
            s_d.rdata[dsa_pkg::CTRL_EN_LSB +: dsa_pkg::NUM_STREAMS]   = s_q.aud_en;
            s_d.rdata[dsa_pkg::CTRL_MUTE_LSB +: dsa_pkg::NUM_STREAMS] = s_q.aud_mute;
         end
         else if (i_s_axi_araddr == dsa_pkg::OFS_CHAN_CNT)
         begin
            s_d.rdata[dsa_pkg::CHAN_W-1:0] = s_q.chan_cnt;
         end
         else if (i_s_axi_araddr == dsa_pkg::OFS_M_VALUE)
         begin
            s_d.rdata[dsa_pkg::MN_W-1:0] = s_q.m_val;
         end
         else if (i_s_axi_araddr == dsa_pkg::OFS_N_VALUE)
         begin
            s_d.rdata[dsa_pkg::MN_W-1:0] = s_q.n_val;
         end
         else if (!((i_s_axi_araddr == dsa_pkg::OFS_INFO_DATA) ||
                    ((i_s_axi_araddr >= dsa_pkg::OFS_EXT_DATA) && (i_s_axi_araddr <= dsa_pkg::OFS_EXT_LAST))))
         begin
            s_d.rresp = dsa_pkg::RESP_SLVERR;
         end
      end
      else if (s_q.rvalid && i_s_axi_rready)
      begin
         s_d.rvalid = 1'b0;
      end

      // Packet sender. Packets wait while every stream has audio disabled.
      case (s_q.snd)
         dsa_pkg::SND_IDLE:
         begin
            if (audio_any && s_q.info_pend)
            begin
               s_d.info_pend = 1'b0;
               s_d.snd_kind  = dsa_pkg::KIND_INFO;
               s_d.snd_idx   = 4'h0;
               s_d.snd       = dsa_pkg::SND_READ;
            end
            else if (audio_any && s_q.ext_pend)
            begin
               s_d.ext_pend = 1'b0;
               s_d.snd_kind = dsa_pkg::KIND_EXT;
               s_d.snd_idx  = 4'h0;
               s_d.snd      = dsa_pkg::SND_READ;
            end
         end
         dsa_pkg::SND_READ:
         begin
            mem_rd_en   = 1'b1;
            mem_rd_addr = (s_q.snd_kind == dsa_pkg::KIND_EXT) ? (dsa_pkg::EXT_BASE + {1'b0, s_q.snd_idx})
                                                              : (dsa_pkg::INFO_BASE + {1'b0, s_q.snd_idx});
            s_d.snd     = dsa_pkg::SND_PUSH;
         end
         dsa_pkg::SND_PUSH:
         begin
            // The read data register holds the word until the buffer has room.
            if (!fifo_full || fifo_pop)
            begin
               push = 1'b1;
               s_d.fifo_data[s_q.fifo_wp]  = mem_rd_data;
               s_d.fifo_first[s_q.fifo_wp] = (s_q.snd_idx == 4'h0);
               s_d.fifo_kind[s_q.fifo_wp]  = s_q.snd_kind;
               if (((s_q.snd_kind == dsa_pkg::KIND_EXT) && (s_q.snd_idx == dsa_pkg::EXT_LAST_IDX)) ||
                   ((s_q.snd_kind == dsa_pkg::KIND_INFO) && (s_q.snd_idx == {1'b0, dsa_pkg::INFO_LAST_IDX})))
               begin
                  s_d.fifo_last[s_q.fifo_wp] = 1'b1;
                  s_d.snd                    = dsa_pkg::SND_IDLE;
               end
               else
               begin
                  s_d.fifo_last[s_q.fifo_wp] = 1'b0;
                  s_d.snd_idx                = s_q.snd_idx + 4'h1;
                  s_d.snd                    = dsa_pkg::SND_READ;
               end
               s_d.fifo_wp = ~s_q.fifo_wp;
            end
         end
         default:
         begin
            s_d.snd = dsa_pkg::SND_IDLE;
         end
      endcase

      // A packet completed in the cycle its flag is taken stays pending.
      if (info_done)
      begin
         s_d.info_pend = 1'b1;
      end
      if (ext_done)
      begin
         s_d.ext_pend = 1'b1;
      end

      if (fifo_pop)
      begin
         s_d.fifo_rp = ~s_q.fifo_rp;
      end
      case ({push, fifo_pop})
         2'b10:   s_d.fifo_cnt = s_q.fifo_cnt + 2'd1;
         2'b01:   s_d.fifo_cnt = s_q.fifo_cnt - 2'd1;
         default: s_d.fifo_cnt = s_q.fifo_cnt;
      endcase
   end

   // ==========================================================================
   // State register
   // ==========================================================================
   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         s_q          <= '0;
         s_q.aud_en   <= dsa_pkg::RST_AUD_EN;
         s_q.aud_mute <= dsa_pkg::RST_AUD_MUTE;
         s_q.chan_cnt <= dsa_pkg::RST_CHAN_CNT;
         s_q.m_val    <= dsa_pkg::RST_MN;
         s_q.n_val    <= dsa_pkg::RST_MN;
         s_q.snd      <= dsa_pkg::SND_IDLE;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // ==========================================================================
   // Packet store
   // ==========================================================================
   dsa_pkt_mem
   #(
      .DATA_W (dsa_pkg::DATA_W),
      .ADDR_W (dsa_pkg::MEM_AW),
      .DEPTH  (dsa_pkg::MEM_DEPTH)
   )
   u_pkt_mem
   (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .i_wr_en    (mem_wr_en),
      .i_wr_addr  (mem_wr_addr),
      .i_wr_data  (i_s_axi_wdata),
      .i_rd_en    (mem_rd_en),
      .i_rd_addr  (mem_rd_addr),
      .o_rd_data  (mem_rd_data)
   );

endmodule // dsa_audio_cfg

// file: dsa_audio_cfg_properties.sv
// Concurrent checks on the ports of the audio packet configuration block.
`timescale 1ns/1ps
module dsa_audio_cfg_properties
(
   input wire logic        i_core_clk,
   input wire logic        i_rst,
   input wire logic [11:0] i_s_axi_awaddr,
   input wire logic        i_s_axi_awvalid,
   input wire logic        i_s_axi_wvalid,
   input wire logic [31:0] i_s_axi_wdata,
   input wire logic [3:0]  i_s_axi_wstrb,
   input wire logic        o_s_axi_bvalid,
   input wire logic        i_mst_mode,
   input wire logic        i_mn_update,
   input wire logic [23:0] i_audio_m,
   input wire logic [3:0]  o_stream_audio_en,
   input wire logic [3:0]  o_stream_audio_mute,
   input wire logic [2:0]  o_audio_channel_count,
   input wire logic [23:0] o_audio_m_value,
   input wire logic        o_pkt_valid,
   input wire logic        i_pkt_ready,
   input wire logic        o_pkt_last,
   input wire logic        o_pkt_kind
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   // ==========
   // Word count of the packet leaving toward the framer
   logic       wr;
   logic [3:0] cnt_q;
   assign wr = i_s_axi_awvalid & i_s_axi_wvalid & !o_s_axi_bvalid;
   always_ff @(posedge i_core_clk or posedge i_rst)
      if (i_rst)
         cnt_q <= 4'h0;
      else if (o_pkt_valid & i_pkt_ready)
         cnt_q <= o_pkt_last ? 4'h0 : cnt_q + 4'h1;
   sequence s_wr(a, b); wr && i_s_axi_awaddr == a && i_s_axi_wstrb[b]; endsequence
   AST_EN_FIRST: assert property (s_wr(12'h300, 0) |=> o_stream_audio_en[0] == $past(i_s_axi_wdata[0]))
      else $error("first enable wrong");
   AST_MUTE_FIRST: assert property (s_wr(12'h300, 2) |=> o_stream_audio_mute[0] == $past(i_s_axi_wdata[16]))
      else $error("first mute wrong");
   AST_EN_SST: assert property (!i_mst_mode |-> o_stream_audio_en[3:1] == 3'h0)
      else $error("stream enable in single mode");
   AST_MUTE_SST: assert property (!i_mst_mode |-> o_stream_audio_mute[3:1] == 3'h0)
      else $error("stream mute in single mode");
   AST_CHAN: assert property (s_wr(12'h304, 0) |=> o_audio_channel_count == $past(i_s_axi_wdata[2:0]))
      else $error("channel count wrong");
   AST_M_LOAD: assert property (i_mn_update |=> o_audio_m_value == $past(i_audio_m))
      else $error("M value not loaded");
   AST_INFO_LEN: assert property (o_pkt_valid && o_pkt_last && !o_pkt_kind |-> cnt_q == 4'h7)
      else $error("infoframe length wrong");
   AST_EXT_LEN: assert property (o_pkt_valid && o_pkt_last && o_pkt_kind |-> cnt_q == 4'h8)
      else $error("extension length wrong");
endmodule // dsa_audio_cfg_properties

// file: dsa_sink_model.sv
// Model of the main-link framer that takes packet words, stalling on request.
`timescale 1ns/1ps
module dsa_sink_model
(
   input  wire logic        i_core_clk,
   input  wire logic        i_stall,
   input  wire logic        i_pkt_valid,
   input  wire logic [31:0] i_pkt_data,
   input  wire logic [2:0]  i_pkt_tag,
   output logic             o_pkt_ready
);
   // Stalling takes a word only every other cycle, so the buffer must hold back the rest.
   logic [35:0] words[$];
   logic        ph = 1'b0;
   assign o_pkt_ready = !i_stall | ph;
   always @(posedge i_core_clk)
   begin
      ph <= ~ph;
      if (i_pkt_valid & o_pkt_ready)
         words.push_back({1'b0, i_pkt_tag, i_pkt_data});
   end
endmodule // dsa_sink_model

// file: tb_top.sv
// Self-checking bench for the audio packet configuration block.
`timescale 1ns/1ps
module tb_top;
   logic        i_core_clk = 1'b0, i_rst = 1'b1, i_s_axi_awvalid = 1'b0, i_s_axi_wvalid = 1'b0, stall = 1'b1;
   logic        i_s_axi_arvalid = 1'b0, i_s_axi_bready = 1'b1, i_s_axi_rready = 1'b1, i_mst_mode = 1'b0;
   logic        i_mn_update = 1'b0, i_pkt_ready, o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid;
   logic        o_s_axi_arready, o_s_axi_rvalid, o_pkt_valid, o_pkt_first, o_pkt_last, o_pkt_kind;
   logic [11:0] i_s_axi_awaddr = 12'h000, i_s_axi_araddr = 12'h000;
   logic [31:0] i_s_axi_wdata = 32'h0000_0000, o_s_axi_rdata, o_pkt_data, q;
   logic [23:0] i_audio_m = 24'h00_0000, i_audio_n = 24'h00_0000, o_audio_m_value, o_audio_n_value;
   logic [3:0]  i_s_axi_wstrb = 4'hF, o_stream_audio_en, o_stream_audio_mute;
   logic [2:0]  o_audio_channel_count;
   logic [1:0]  o_s_axi_bresp, o_s_axi_rresp, r;
   int          bad_count = 0, comparisons = 0, n;
   dsa_audio_cfg i_dut (.*);
   dsa_sink_model i_sink (.i_core_clk, .i_stall(stall), .i_pkt_valid(o_pkt_valid), .i_pkt_data(o_pkt_data),
      .i_pkt_tag({o_pkt_kind, o_pkt_first, o_pkt_last}), .o_pkt_ready(i_pkt_ready));
   initial forever #50 i_core_clk = ~i_core_clk;
   // ==========
   // Bus and comparison tasks
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
         bad_count++;
      end
   endtask
   // Ready is looked at on the falling edge so the taking rising edge is known without a race.
   task automatic bus(input logic rd, input logic [11:0] a, input logic [31:0] d);
      n = 0;
      @(posedge i_core_clk);
      i_s_axi_arvalid <= rd;
      i_s_axi_awvalid <= !rd;
      i_s_axi_wvalid <= !rd;
      i_s_axi_araddr <= a;
      i_s_axi_awaddr <= a;
      i_s_axi_wdata <= d;
      do @(negedge i_core_clk); while (!(rd ? o_s_axi_arready : o_s_axi_awready) && ++n < 20);
      @(posedge i_core_clk);
      i_s_axi_arvalid <= 1'b0;
      i_s_axi_awvalid <= 1'b0;
      i_s_axi_wvalid <= 1'b0;
      do @(negedge i_core_clk); while (!(rd ? o_s_axi_rvalid : o_s_axi_bvalid) && ++n < 20);
      bad_count += (n >= 20);
      if (n >= 20) conclude();
      r = rd ? o_s_axi_rresp : o_s_axi_bresp;
      q = o_s_axi_rdata;
   endtask
   task automatic rchk(input logic [11:0] a, input logic [35:0] exp);
      bus(1'b1, a, 32'h0000_0000);
      chk({2'b00, r, q}, exp);
   endtask
   task automatic pk(input int at, input int cnt, input logic kind, input logic [31:0] base);
      for (int k = 0; k < cnt; k++)
         chk(i_sink.words[at + k], {1'b0, kind, k == 0, k == cnt - 1, base + k});
   endtask
   initial
   begin
      repeat (6) @(posedge i_core_clk);
      i_rst <= 1'b0;
      rchk(12'h300, 36'h0);
      rchk(12'h304, 36'h0);
      rchk(12'h328, 36'h0);
      rchk(12'h32C, 36'h0);
      rchk(12'h308, 36'h0);
      rchk(12'h3FC, 36'h2_0000_0000);
      $display("reset test over");
      bus(1'b0, 12'h300, 32'h000F_000F);
      rchk(12'h300, 36'h0_000F_000F);
      chk({o_stream_audio_mute, o_stream_audio_en}, 36'h11);
      @(posedge i_core_clk);
      i_mst_mode <= 1'b1;
      bus(1'b0, 12'h304, 32'h0000_0005);
      chk({o_stream_audio_mute, o_stream_audio_en}, 36'hFF);
      chk(o_audio_channel_count, 36'h5);
      bus(1'b0, 12'h328, 32'h0012_3456);
      chk(o_audio_m_value, 36'h12_3456);
      @(posedge i_core_clk);
      i_audio_m <= 24'hAB_CDEF;
      i_audio_n <= 24'h65_4321;
      i_mn_update <= 1'b1;
      @(posedge i_core_clk);
      i_mn_update <= 1'b0;
      rchk(12'h32C, 36'h0_0065_4321);
      chk(o_audio_m_value, 36'hAB_CDEF);
      chk(o_audio_n_value, 36'h65_4321);
      $display("register test over");
      // Audio is off while loading, so both extension packets wait and only the newer one may leave.
      bus(1'b0, 12'h300, 32'h0000_0000);
      for (int k = 0; k < 18; k++) bus(1'b0, 12'h330 + 12'(4 * (k % 9)), 32'hA000_0000 + k);
      for (int k = 0; k < 8; k++) bus(1'b0, 12'h308, 32'hC000_0000 + k);
      bus(1'b0, 12'h300, 32'h0000_0001);
      n = 0;
      while (i_sink.words.size() < 17 && ++n < 600) @(negedge i_core_clk);
      bad_count += (n >= 600);
      repeat (40) @(negedge i_core_clk);
      chk(i_sink.words.size(), 36'h11);
      pk(0, 8, 1'b0, 32'hC000_0000);
      pk(8, 9, 1'b1, 32'hA000_0009);
      $display("packet test over");
      conclude();
   end
endmodule // tb_top
bind dsa_audio_cfg dsa_audio_cfg_properties i_chk (.*);
